// ==== rps_pkg.sv ====
// Constants for the reset, power-down and strap latch block
`default_nettype none
package rps_pkg;
	// Timing
	localparam int         CLK_PERIOD_NS = 10;
	localparam int         HRST_MIN_NS   = 1000;
	localparam int         HRST_MIN_CYC  = (HRST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [7:0] HRST_CNT_MAX  = 8'(HRST_MIN_CYC);
	localparam logic [7:0] SETTLE_CYC    = 8'h04;
	// Strap defaults: bit 0 pulled up, bits 4..1 pulled down
	localparam logic [4:0] STRAP_DFLT    = 5'h01;
	localparam logic [4:0] ISOLATE_ADDR  = 5'h00;
	// Register offsets (byte addresses)
	localparam logic [7:0] CTRL_OFF            = 8'h00;
	localparam logic [7:0] PHY_CONTROL_REG_OFF = 8'h04;
	localparam logic [7:0] STRAP_OFF           = 8'h08;
	localparam logic [7:0] IRQ_STAT_OFF        = 8'h0c;
	localparam logic [7:0] IRQ_MASK_OFF        = 8'h10;
	localparam logic [7:0] STATUS_OFF          = 8'h14;
	// Control register fields
	localparam int         CTRL_SWRST    = 0;
	localparam int         CTRL_IRQ_MODE = 1;
	localparam int         CTRL_PD_FORCE = 2;
	// PHY control register fields
	localparam int         PCR_ADDR_LSB  = 0;
	localparam int         PCR_ISOLATE   = 5;
	// Interrupt event bits
	localparam int         EV_W          = 4;
	localparam int         EV_RST_DONE   = 0;
	localparam int         EV_PD_ON      = 1;
	localparam int         EV_PD_OFF     = 2;
	localparam int         EV_SWRST      = 3;
	localparam logic [3:0] IRQ_MASK_RST  = 4'h0;
	// Status register fields
	localparam int         STAT_PD       = 0;
	localparam int         STAT_ISOLATE  = 1;
	localparam int         STAT_IRQ_MODE = 2;
	localparam int         STAT_TRST     = 3;
endpackage
`default_nettype wire

// ==== rps_top.sv ====
// Reset, power-down pin and strap latch control with Wishbone registers
//
// Operation
// - Hard reset low 1 us starts full reset
// - Hard reset restores every register default
// - Hard reset re-samples all strap options
// - Straps sampled at hard reset; power-up captures STRAP_DFLT
// - Software reset reloads captured straps, no resample
// - Shared pin defaults to power-down input
// - Shared pin low enters power-down mode while interrupt mode is off
// - Register access keeps working in power-down
// - Register bit turns pin into interrupt output
// - Interrupt mode drives shared pin low while an unmasked interrupt is pending
// - Address straps latched into PHY control register
// - Any strapped address 0 to 31 accepted
// - Strapped address zero selects MII isolate
// - Writing address zero never selects isolate
// - Undriven straps default to address one
// - Test reset input is active low
`timescale 1ns/10ps
`default_nettype none
module rps_top (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        hard_reset_n_i,
	input  wire logic [4:0]  phy_addr_strap_i,
	input  wire logic        powerdown_or_irq_pin_n_i,
	output logic             powerdown_or_irq_pin_n_o,
	output logic             powerdown_or_irq_pin_n_oe_o,
	input  wire logic        test_reset_n_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic [31:0]      wb_dat_o,
	output logic             wb_ack_o,
	output logic             irq_o,
	output logic             power_down_o,
	output logic             mii_isolate_o,
	output logic [4:0]       phy_addr_o,
	output logic             core_reset_o,
	output logic             test_reset_o
);
	import rps_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// State

	typedef enum logic [1:0] {
		RPS_RUN,
		RPS_HOLD,
		RPS_CAPTURE
	} rps_state_e;

	typedef struct packed {
		rps_state_e  state;
		logic [7:0]  cnt;
		logic        hr_s1;
		logic        hr_s2;
		logic        hr_s3;
		logic        hr_f;
		logic        pn_s1;
		logic        pn_s2;
		logic        pn_s3;
		logic        pn_f;
		logic        tr_s1;
		logic        tr_s2;
		logic        tr_s3;
		logic        tr_f;
		logic [4:0]  sp_s1;
		logic [4:0]  sp_s2;
		logic [4:0]  sp_s3;
		logic [4:0]  sp_f;
		logic [4:0]  strap;
		logic [4:0]  addr;
		logic        iso;
		logic        irq_mode;
		logic        pd_force;
		logic        pd;
		logic [3:0]  istat;
		logic [3:0]  imask;
		logic        ack;
		logic [31:0] dat;
		logic        irq;
		logic        pin_oe;
		logic        pin_do;
		logic        core_rst;
		logic        test_rst;
	} rps_regs_s;

	rps_regs_s         st;
	rps_regs_s         next_st;
	logic              bus_req;
	logic              bus_wr;
	logic              bus_rd;
	logic [EV_W-1:0]   ev;

	////////////////////////////////////////////////////////////////////////
	// Helpers

	// Accept a new level only once two late stages agree
	function automatic logic rps_filt(input logic s2, input logic s3, input logic old);
		rps_filt = (s2 == s3) ? s2 : old;
	endfunction

	// Software-visible defaults; address reloads from the last capture
	function automatic rps_regs_s rps_dflt(input rps_regs_s s);
		rps_regs_s r;
		r = s;
		r.addr = s.strap;
		r.iso = (s.strap == ISOLATE_ADDR);
		r.irq_mode = 1'b0;
		r.pd_force = 1'b0;
		r.pd = 1'b0;
		r.istat = '0;
		r.imask = IRQ_MASK_RST;
		return r;
	endfunction

	assign bus_req = wb_cyc_i & wb_stb_i & ~st.ack;
	assign bus_wr = bus_req & wb_we_i;
	assign bus_rd = bus_req & ~wb_we_i;

	////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		next_st = st;
		ev = '0;

		// Pin synchronisers; first stage feeds only the second
		next_st.hr_s1 = hard_reset_n_i;
		next_st.hr_s2 = st.hr_s1;
		next_st.hr_s3 = st.hr_s2;
		next_st.hr_f = rps_filt(st.hr_s2, st.hr_s3, st.hr_f);
		next_st.pn_s1 = powerdown_or_irq_pin_n_i;
		next_st.pn_s2 = st.pn_s1;
		next_st.pn_s3 = st.pn_s2;
		next_st.pn_f = rps_filt(st.pn_s2, st.pn_s3, st.pn_f);
		next_st.tr_s1 = test_reset_n_i;
		next_st.tr_s2 = st.tr_s1;
		next_st.tr_s3 = st.tr_s2;
		next_st.tr_f = rps_filt(st.tr_s2, st.tr_s3, st.tr_f);
		next_st.sp_s1 = phy_addr_strap_i;
		next_st.sp_s2 = st.sp_s1;
		next_st.sp_s3 = st.sp_s2;
		for (int i = 0; i < 5; i++) begin
			next_st.sp_f[i] = rps_filt(st.sp_s2[i], st.sp_s3[i], st.sp_f[i]);
		end

		// Bus answers in every state, power-down included
		next_st.ack = bus_req;
		next_st.dat = '0;
		if (bus_rd) begin
			unique case (wb_adr_i)
				CTRL_OFF: begin
					next_st.dat[CTRL_IRQ_MODE] = st.irq_mode;
					next_st.dat[CTRL_PD_FORCE] = st.pd_force;
				end
				PHY_CONTROL_REG_OFF: begin
					next_st.dat[PCR_ADDR_LSB +: 5] = st.addr;
					next_st.dat[PCR_ISOLATE] = st.iso;
				end
				STRAP_OFF: begin
					next_st.dat[4:0] = st.strap;
				end
				IRQ_STAT_OFF: begin
					next_st.dat[EV_W-1:0] = st.istat;
				end
				IRQ_MASK_OFF: begin
					next_st.dat[EV_W-1:0] = st.imask;
				end
				STATUS_OFF: begin
					next_st.dat[STAT_PD] = st.pd;
					next_st.dat[STAT_ISOLATE] = st.iso;
					next_st.dat[STAT_IRQ_MODE] = st.irq_mode;
					next_st.dat[STAT_TRST] = st.test_rst;
				end
				default: begin
					next_st.dat = '0;
				end
			endcase
			if (wb_adr_i == IRQ_STAT_OFF) begin
				next_st.istat = '0;
			end
		end

		unique case (st.state)
			RPS_RUN: begin
				// Filtered input must stay low the full minimum time
				if (!st.hr_f) begin
					next_st.cnt = st.cnt + 8'h01;
				end else begin
					next_st.cnt = '0;
				end
				if (!st.hr_f && st.cnt == HRST_CNT_MAX - 8'h01) begin
					next_st = rps_dflt(next_st);
					next_st.state = RPS_HOLD;
					next_st.cnt = '0;
				end else if (bus_wr && wb_sel_i[0] && wb_adr_i == CTRL_OFF &&
						wb_dat_i[CTRL_SWRST]) begin
					// Straps are not resampled here, only reloaded
					next_st = rps_dflt(next_st);
					ev[EV_SWRST] = 1'b1;
				end else begin
					if (bus_wr && wb_sel_i[0]) begin
						unique case (wb_adr_i)
							CTRL_OFF: begin
								next_st.irq_mode = wb_dat_i[CTRL_IRQ_MODE];
								next_st.pd_force = wb_dat_i[CTRL_PD_FORCE];
							end
							PHY_CONTROL_REG_OFF: begin
								// Isolate follows only the strap
								next_st.addr = wb_dat_i[PCR_ADDR_LSB +: 5];
							end
							IRQ_MASK_OFF: begin
								next_st.imask = wb_dat_i[EV_W-1:0];
							end
							default: begin
								next_st.imask = next_st.imask;
							end
						endcase
					end
					// Pin counts as power-down only while interrupt mode is off
					next_st.pd = st.pd_force | (~st.irq_mode & ~st.pn_f);
					ev[EV_PD_ON] = next_st.pd & ~st.pd;
					ev[EV_PD_OFF] = ~next_st.pd & st.pd;
				end
			end
			RPS_HOLD: begin
				next_st = rps_dflt(next_st);
				next_st.cnt = '0;
				if (st.hr_f) begin
					next_st.state = RPS_CAPTURE;
				end
			end
			RPS_CAPTURE: begin
				// Wait SETTLE_CYC cycles; after power-up sp_f still holds STRAP_DFLT at capture
				next_st = rps_dflt(next_st);
				next_st.cnt = st.cnt + 8'h01;
				if (st.cnt == SETTLE_CYC - 8'h01) begin
					next_st.strap = st.sp_f;
					next_st.addr = st.sp_f;
					next_st.iso = (st.sp_f == ISOLATE_ADDR);
					next_st.state = RPS_RUN;
					next_st.cnt = '0;
					ev[EV_RST_DONE] = 1'b1;
				end
			end
			default: begin
				// Illegal code falls back into the reset hold
				next_st = rps_dflt(next_st);
				next_st.state = RPS_HOLD;
			end
		endcase

		// Set wins over read clear
		next_st.istat = next_st.istat | ev;
		next_st.irq = |(next_st.istat & next_st.imask);
		next_st.pin_oe = next_st.irq_mode & next_st.irq;
		next_st.pin_do = 1'b0;
		next_st.core_rst = (next_st.state != RPS_RUN);
		next_st.test_rst = ~next_st.tr_f;

		if (rst_i) begin
			next_st = '0;
			next_st.state = RPS_CAPTURE;
			next_st.hr_s1 = 1'b1;
			next_st.hr_s2 = 1'b1;
			next_st.hr_s3 = 1'b1;
			next_st.hr_f = 1'b1;
			next_st.pn_s1 = 1'b1;
			next_st.pn_s2 = 1'b1;
			next_st.pn_s3 = 1'b1;
			next_st.pn_f = 1'b1;
			next_st.tr_s1 = 1'b1;
			next_st.tr_s2 = 1'b1;
			next_st.tr_s3 = 1'b1;
			next_st.tr_f = 1'b1;
			next_st.sp_s1 = STRAP_DFLT;
			next_st.sp_s2 = STRAP_DFLT;
			next_st.sp_s3 = STRAP_DFLT;
			next_st.sp_f = STRAP_DFLT;
			next_st.strap = STRAP_DFLT;
			next_st.addr = STRAP_DFLT;
			next_st.imask = IRQ_MASK_RST;
			next_st.core_rst = 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		st <= next_st;
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs

	assign powerdown_or_irq_pin_n_o = st.pin_do;
	assign powerdown_or_irq_pin_n_oe_o = st.pin_oe;
	assign wb_dat_o = st.dat;
	assign wb_ack_o = st.ack;
	assign irq_o = st.irq;
	assign power_down_o = st.pd;
	assign mii_isolate_o = st.iso;
	assign phy_addr_o = st.addr;
	assign core_reset_o = st.core_rst;
	assign test_reset_o = st.test_rst;

	////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking rps_cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	AST_HRST_ENTER: assert property (
		(st.state == RPS_RUN && !st.hr_f && st.cnt == HRST_CNT_MAX - 8'h01) |=> core_reset_o
	) else $error("Long hard reset not taken");

	AST_HRST_MIN: assert property (
		$rose(core_reset_o) |-> ($past(st.cnt) == HRST_CNT_MAX - 8'h01 && !$past(st.hr_f))
	) else $error("Reset entered before minimum low time");

	AST_DFLT: assert property (
		core_reset_o |-> (st.imask == IRQ_MASK_RST && !st.pd_force && !power_down_o && st.istat == '0)
	) else $error("Register not at default during reset");

	AST_CAPTURE: assert property (
		(st.state == RPS_CAPTURE && st.cnt == SETTLE_CYC - 8'h01) |=>
		(phy_addr_o == $past(st.sp_f) && st.strap == $past(st.sp_f) && !core_reset_o)
	) else $error("Straps not captured at reset release");

	AST_SWRST: assert property (
		(st.state == RPS_RUN && st.hr_f && bus_wr && wb_sel_i[0] && wb_adr_i == CTRL_OFF &&
			wb_dat_i[CTRL_SWRST]) |=> (phy_addr_o == $past(st.strap) && $stable(st.strap) && !st.irq_mode)
	) else $error("Software reset did not reload straps");

	AST_PIN_DFLT: assert property (
		core_reset_o |-> (!st.irq_mode && !powerdown_or_irq_pin_n_oe_o)
	) else $error("Shared pin not an input after reset");

	AST_PD_ENTER: assert property (
		(st.state == RPS_RUN && next_st.state == RPS_RUN && !st.irq_mode && !st.pn_f) |=> power_down_o
	) else $error("Pin low did not enter power-down");

	AST_BUS_PD: assert property (
		(power_down_o && wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o
	) else $error("Bus stalled in power-down");

	AST_IRQ_PIN: assert property (
		powerdown_or_irq_pin_n_oe_o == (st.irq_mode && irq_o && !powerdown_or_irq_pin_n_o)
	) else $error("Shared pin drive disagrees with interrupt");

	AST_ADDR_WR: assert property (
		(st.state == RPS_RUN && next_st.state == RPS_RUN && bus_wr && wb_sel_i[0] &&
			wb_adr_i == PHY_CONTROL_REG_OFF) |=> (phy_addr_o == $past(wb_dat_i[4:0]) && $stable(mii_isolate_o))
	) else $error("Address write wrong or moved isolate");

	AST_ISO: assert property (
		!core_reset_o |-> (mii_isolate_o == (st.strap == ISOLATE_ADDR))
	) else $error("Isolate does not follow strapped address");

	AST_TRST: assert property (
		(!st.tr_s2 && !st.tr_s3) |=> test_reset_o
	) else $error("Test reset low not seen");

	AST_HOLD: assert property (
		(core_reset_o && st.state == RPS_HOLD && !st.hr_f) |=> core_reset_o
	) else $error("Reset released while input low");

endmodule
`default_nettype wire

// ==== rps_board.sv ====
// Board model: strap pulls, shared pin wire and hard reset source
`timescale 1ns/10ps
`default_nettype none
module rps_board (
	input  wire logic       clk_i,
	input  wire logic       pd_pull_low_i,
	input  wire logic       dut_pin_o_i,
	input  wire logic       dut_pin_oe_i,
	input  wire logic       strap_en_i,
	input  wire logic [4:0] strap_val_i,
	input  wire logic       hrst_go_i,
	input  wire logic [7:0] hrst_len_i,
	output logic            pin_o,
	output logic [4:0]      strap_o,
	output logic            hard_reset_n_o
);
	logic [7:0] cnt = 8'h00;

	// Pull-up on the wire; either party may pull it low
	assign pin_o = !((dut_pin_oe_i && !dut_pin_o_i) || pd_pull_low_i);
	// Undriven straps fall back to the internal pulls
	assign strap_o = strap_en_i ? strap_val_i : 5'h01;
	always @(posedge clk_i) begin
		if (hrst_go_i)
			cnt <= hrst_len_i;
		else if (cnt != 8'h00)
			cnt <= cnt - 8'h01;
	end
	assign hard_reset_n_o = (cnt == 8'h00);
endmodule
`default_nettype wire

// ==== tb_rps_top.sv ====
// Self-checking bench for the reset, power-down and strap latch block
`timescale 1ns/10ps
`default_nettype none
module tb_rps_top;
	import rps_pkg::*;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        pd_low = 1'b0;
	logic        strap_en = 1'b0;
	logic [4:0]  strap_val = 5'h00;
	logic        hrst_go = 1'b0;
	logic [7:0]  hrst_len = 8'h00;
	logic        test_reset_n = 1'b1;
	logic        wb_cyc = 1'b0;
	logic        wb_stb = 1'b0;
	logic        wb_we = 1'b0;
	logic [3:0]  wb_sel = 4'h0;
	logic [7:0]  wb_adr = 8'h00;
	logic [31:0] wb_wdat = 32'h0;
	logic [31:0] wb_rdat;
	logic        wb_ack, irq, pd_mode, isolate, core_rst, trst, pin, pin_o, pin_oe, hrst_n;
	logic [4:0]  strap, phy_addr;
	int          failures = 0;
	int          n_checks = 0;
	int          cycles = 0;

	always #5 clk_i = ~clk_i;

	rps_board BOARD (.clk_i(clk_i), .pd_pull_low_i(pd_low), .dut_pin_o_i(pin_o), .dut_pin_oe_i(pin_oe),
		.strap_en_i(strap_en), .strap_val_i(strap_val), .hrst_go_i(hrst_go), .hrst_len_i(hrst_len),
		.pin_o(pin), .strap_o(strap), .hard_reset_n_o(hrst_n));

	rps_top DUT (.clk_i(clk_i), .rst_i(rst_i), .hard_reset_n_i(hrst_n), .phy_addr_strap_i(strap),
		.powerdown_or_irq_pin_n_i(pin), .powerdown_or_irq_pin_n_o(pin_o),
		.powerdown_or_irq_pin_n_oe_o(pin_oe), .test_reset_n_i(test_reset_n), .wb_cyc_i(wb_cyc),
		.wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat),
		.wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .irq_o(irq), .power_down_o(pd_mode),
		.mii_isolate_o(isolate), .phy_addr_o(phy_addr), .core_reset_o(core_rst), .test_reset_o(trst));

	////////////////////////////////////////////////////////////////////////
	task automatic print_verdict;
		$display("checks=%0d failures=%0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic cyc(input int k);
		repeat (k) @(posedge clk_i);
	endtask

	// Entered just after a rising edge; holds the request until ack is seen
	task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		wb_sel <= 4'hf;
		wb_adr <= a;
		wb_wdat <= wd;
		// Only the bench timeout ends this wait
		do begin
			@(posedge clk_i);
		end while (wb_ack !== 1'b1);
		rd = wb_rdat;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		wb_sel <= 4'h0;
		@(posedge clk_i);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		bus(1'b1, a, d, x);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] x;
		bus(1'b0, a, 32'h0, x);
		chk(x, exp);
	endtask

	task automatic wait_idle;
		int n;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (core_rst !== 1'b0 && n < 200);
		if (n >= 200)
			failures++;
	endtask

	task automatic hard_reset(input logic [7:0] len);
		hrst_len <= len;
		hrst_go <= 1'b1;
		@(posedge clk_i);
		hrst_go <= 1'b0;
		cyc(int'(len));
	endtask

	// Hang guard, generous against roughly 450 expected cycles
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 5000) begin
			failures++;
			print_verdict();
		end
	end

	////////////////////////////////////////////////////////////////////////
	initial begin
		cyc(10);
		rst_i <= 1'b0;
		wait_idle();
		chk(32'(phy_addr), 32'h01);
		chk(32'(isolate), 32'h0);
		rd(PHY_CONTROL_REG_OFF, 32'h01);
		rd(IRQ_MASK_OFF, 32'h0);
		rd(IRQ_STAT_OFF, 32'h1);
		rd(IRQ_STAT_OFF, 32'h0);
		rd(8'h1c, 32'h0);
		$display("test power-up done");

		wr(PHY_CONTROL_REG_OFF, 32'h0);
		rd(PHY_CONTROL_REG_OFF, 32'h0);
		chk(32'(isolate), 32'h0);
		$display("test address write done");

		wr(IRQ_MASK_OFF, 32'h2);
		pd_low <= 1'b1;
		cyc(8);
		chk(32'(pd_mode), 32'h1);
		chk(32'(irq), 32'h1);
		chk(32'(pin_oe), 32'h0);
		rd(STATUS_OFF, 32'h1);
		rd(IRQ_STAT_OFF, 32'h2);
		pd_low <= 1'b0;
		cyc(8);
		chk(32'(pd_mode), 32'h0);
		wr(IRQ_MASK_OFF, 32'h4);
		wr(CTRL_OFF, 32'h2);
		cyc(2);
		chk(32'(pin_oe), 32'h1);
		chk(32'(pin), 32'h0);
		cyc(6);
		chk(32'(pd_mode), 32'h0);
		rd(IRQ_STAT_OFF, 32'h4);
		cyc(2);
		chk(32'(pin_oe), 32'h0);
		chk(32'(irq), 32'h0);
		$display("test power-down and interrupt done");

		hard_reset(8'd50);
		cyc(10);
		chk(32'(core_rst), 32'h0);
		strap_en <= 1'b1;
		hard_reset(8'd110);
		chk(32'(core_rst), 32'h1);
		wait_idle();
		chk(32'(phy_addr), 32'h0);
		chk(32'(isolate), 32'h1);
		rd(IRQ_MASK_OFF, 32'h0);
		rd(CTRL_OFF, 32'h0);
		$display("test hard reset done");

		strap_val <= 5'h1f;
		cyc(5);
		wr(PHY_CONTROL_REG_OFF, 32'h07);
		wr(CTRL_OFF, 32'h1);
		cyc(4);
		chk(32'(phy_addr), 32'h0);
		chk(32'(isolate), 32'h1);
		rd(STRAP_OFF, 32'h0);
		rd(IRQ_STAT_OFF, 32'h8);
		hard_reset(8'd110);
		wait_idle();
		chk(32'(phy_addr), 32'h1f);
		chk(32'(isolate), 32'h0);
		$display("test software reset done");

		test_reset_n <= 1'b0;
		cyc(8);
		chk(32'(trst), 32'h1);
		rd(STATUS_OFF, 32'h8);
		test_reset_n <= 1'b1;
		cyc(8);
		chk(32'(trst), 32'h0);
		$display("test test reset done");

		wr(CTRL_OFF, 32'h4);
		cyc(2);
		chk(32'(pd_mode), 32'h1);
		rd(STATUS_OFF, 32'h1);
		$display("test forced power-down done");
		print_verdict();
	end
endmodule
`default_nettype wire
